// file: rtl/sync_control_status_host_pins.sv
// Purpose: Control straps, status pins, SPI/I2C host port and interrupt pin
// Assumes: Loop status arrives on ref_clk; pins and serial clock are asynchronous
// Notes: Open-drain pins drive low while their enable is high
`timescale 1ns/1ps
`default_nettype none
module sync_control_status_host_pins (
    input  wire logic                         ref_clk,
    input  wire logic                         rst,
    input  wire logic                         ce,
    input  wire sync_ctl_pkg::strap_pins_t    strap_pins,
    input  wire sync_ctl_pkg::loop_status_t   loop_status,
    input  wire sync_ctl_pkg::host_pins_in_t  host_in,
    output logic [1:0]                        loop_a_mode,
    output logic                              slave_role,
    output logic                              diff_out_a_drive,
    output logic                              diff_out_b_drive,
    output logic                              loop_a_locked,
    output logic                              loop_a_in_hold,
    output sync_ctl_pkg::host_pins_out_t      host_out,
    output logic                              int_n_o,
    output logic                              int_oe
);
    import sync_ctl_pkg::*;

    strap_pins_t    strap_s;
    host_pins_in_t  host_s;
    host_pins_in_t  host_d;
    host_pins_out_t next_host_out;
    logic           i2c_mode;
    logic           sck_rise;
    logic           sck_fall;
    logic           i2c_start;
    logic           i2c_stop;
    logic [7:0]     loop_a_mode_select;
    logic [7:0]     role_ctl;
    logic [7:0]     irq_service_regs;
    logic [7:0]     irq_enable;
    logic [7:0]     next_mode_select;
    logic [7:0]     next_role_ctl;
    logic [7:0]     next_irq_service_regs;
    logic [7:0]     next_ien;
    logic [7:0]     events;
    logic [7:0]     clr_bits;
    logic [1:0]     next_loop_a_mode;
    logic           next_slave_role;
    logic           next_int_oe;
    logic           wr_en;
    logic [6:0]     wr_addr;
    logic [7:0]     wr_data;
    logic [3:0]     spi_cnt;
    logic [3:0]     next_spi_cnt;
    logic [7:0]     spi_sh;
    logic [7:0]     next_spi_sh;
    logic [7:0]     spi_out;
    logic [7:0]     next_spi_out;
    logic [6:0]     spi_addr;
    logic [6:0]     next_spi_addr;
    logic           spi_rd;
    logic           next_spi_rd;
    logic           spi_byte;
    logic           next_spi_byte;
    logic           spi_wr;
    logic [7:0]     spi_wdata;
    logic           next_so;
    logic           next_so_oe;
    i2c_state_t     i2c_st;
    i2c_state_t     next_i2c_st;
    logic [3:0]     i2c_cnt;
    logic [3:0]     next_i2c_cnt;
    logic [7:0]     i2c_sh;
    logic [7:0]     next_i2c_sh;
    logic [1:0]     i2c_idx;
    logic [1:0]     next_i2c_idx;
    logic [6:0]     i2c_ptr;
    logic [6:0]     next_i2c_ptr;
    logic           i2c_rd;
    logic           next_i2c_rd;
    logic           i2c_ack;
    logic           next_i2c_ack;
    logic           i2c_wr;
    logic           next_sda_oe;
    logic [7:0]     rd_byte;

    // Register read decode shared by both host ports
    function automatic logic [7:0] reg_read(input logic [6:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == REG_MODE)
            v = loop_a_mode_select;
        else if (a == REG_ROLE)
            v = role_ctl;
        else if (a == REG_STATUS)
        begin
            v[ST_LOCK_BIT]  = loop_a_locked;
            v[ST_HOLD_BIT]  = loop_a_in_hold;
            v[ST_SLAVE_BIT] = slave_role;
            v[ST_I2C_BIT]   = i2c_mode;
        end
        else if (a == REG_IRQ_SVC)
            v = irq_service_regs;
        else if (a == REG_IEN)
            v = irq_enable;
        return v;
    endfunction

    // Pin synchronisers
    sync_bank #(
        .WIDTH($bits(strap_pins_t) + $bits(host_pins_in_t))
    ) u_sync (
        .ref_clk(ref_clk),
        .ce     (ce),
        .d      ({strap_pins, host_in}),
        .q      ({strap_s, host_s})
    );

    // Edge and bus condition detection on synchronised pins
    assign i2c_mode  = strap_s.i2c_select_pin;
    assign sck_rise  = host_s.sck_scl & ~host_d.sck_scl;
    assign sck_fall  = ~host_s.sck_scl & host_d.sck_scl;
    assign i2c_start = host_s.sck_scl & host_d.sck_scl & host_d.si_sda & ~host_s.si_sda;
    assign i2c_stop  = host_s.sck_scl & host_d.sck_scl & ~host_d.si_sda & host_s.si_sda;

    // I2C read data; a process so that register changes reach it
    always_comb
    begin
        rd_byte = reg_read(i2c_ptr);
    end

    // Write port from whichever host interface is selected
    assign wr_en   = i2c_mode ? i2c_wr : spi_wr;
    assign wr_addr = i2c_mode ? i2c_ptr : spi_addr;
    assign wr_data = i2c_mode ? i2c_sh : spi_wdata;

    // Control, status and interrupt next values
    always_comb
    begin
        next_mode_select = loop_a_mode_select;
        next_role_ctl    = role_ctl;
        next_ien         = irq_enable;
        clr_bits         = 8'h00;
        if (wr_en && wr_addr == REG_MODE)
            next_mode_select = wr_data & MODE_WR_MASK;
        else if (wr_en && wr_addr == REG_ROLE)
            next_role_ctl = wr_data & ROLE_WR_MASK;
        else if (wr_en && wr_addr == REG_IRQ_SVC)
            clr_bits = wr_data;
        else if (wr_en && wr_addr == REG_IEN)
            next_ien = wr_data & EV_MASK;
        events              = 8'h00;
        events[EV_LOCK_BIT] = loop_status.locked != loop_a_locked;
        events[EV_HOLD_BIT] = loop_status.in_hold != loop_a_in_hold;
        next_irq_service_regs = ((irq_service_regs & ~clr_bits) | events) & EV_MASK;
        if (loop_a_mode_select[MODE_SW_BIT])
            next_loop_a_mode = loop_a_mode_select[1:0];
        else
            next_loop_a_mode = {strap_s.loop_a_mode_pin_hi, strap_s.loop_a_mode_pin_lo};
        if (role_ctl[ROLE_SW_BIT])
            next_slave_role = role_ctl[ROLE_SLAVE_BIT];
        else
            next_slave_role = strap_s.role_slave_pin;
        next_int_oe = |(irq_service_regs & irq_enable);
    end

    // Control, status and interrupt registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            loop_a_mode_select <= {MODE_RST_HI, strap_s.loop_a_mode_pin_hi,
                                   strap_s.loop_a_mode_pin_lo};
            loop_a_mode        <= {strap_s.loop_a_mode_pin_hi, strap_s.loop_a_mode_pin_lo};
            role_ctl           <= ROLE_RST;
            irq_service_regs   <= IRQ_SVC_RST;
            irq_enable         <= IEN_RST;
            slave_role         <= 1'b0;
            diff_out_a_drive   <= 1'b0;
            diff_out_b_drive   <= 1'b0;
            loop_a_locked      <= 1'b0;
            loop_a_in_hold     <= 1'b0;
            int_oe             <= 1'b0;
            int_n_o            <= 1'b0;
            host_d             <= '0;
        end
        else if (ce)
        begin
            loop_a_mode_select <= next_mode_select;
            loop_a_mode        <= next_loop_a_mode;
            role_ctl           <= next_role_ctl;
            irq_service_regs   <= next_irq_service_regs;
            irq_enable         <= next_ien;
            slave_role         <= next_slave_role;
            diff_out_a_drive   <= strap_s.diff_out_a_enable;
            diff_out_b_drive   <= strap_s.diff_out_b_enable;
            loop_a_locked      <= loop_status.locked;
            loop_a_in_hold     <= loop_status.in_hold;
            int_oe             <= next_int_oe;
            int_n_o            <= 1'b0;
            host_d             <= host_s;
        end
    end

    // SPI slave, mode 0: command byte then data byte
    always_comb
    begin
        next_spi_cnt  = spi_cnt;
        next_spi_sh   = spi_sh;
        next_spi_out  = spi_out;
        next_spi_addr = spi_addr;
        next_spi_rd   = spi_rd;
        next_spi_byte = spi_byte;
        next_so       = host_out.so;
        spi_wr        = 1'b0;
        spi_wdata     = {spi_sh[6:0], host_s.si_sda};
        if (i2c_mode || host_s.host_select_or_addr_bit)
        begin
            next_spi_cnt  = 4'h0;
            next_spi_byte = 1'b0;
        end
        else
        begin
            if (sck_rise)
            begin
                next_spi_sh = spi_wdata;
                if (spi_cnt == SPI_LAST)
                begin
                    next_spi_cnt = 4'h0;
                    if (!spi_byte)
                    begin
                        next_spi_addr = spi_wdata[6:0];
                        next_spi_rd   = spi_wdata[SPI_READ_BIT];
                        next_spi_byte = 1'b1;
                        next_spi_out  = reg_read(spi_wdata[6:0]);
                    end
                    else if (!spi_rd)
                        spi_wr = 1'b1;
                end
                else
                    next_spi_cnt = spi_cnt + 4'h1;
            end
            if (sck_fall && spi_byte && spi_rd)
            begin
                next_so      = spi_out[7];
                next_spi_out = {spi_out[6:0], 1'b0};
            end
        end
        next_so_oe = ~i2c_mode;
    end

    // I2C slave: address, register pointer, then data bytes
    always_comb
    begin
        next_i2c_st  = i2c_st;
        next_i2c_cnt = i2c_cnt;
        next_i2c_sh  = i2c_sh;
        next_i2c_idx = i2c_idx;
        next_i2c_ptr = i2c_ptr;
        next_i2c_rd  = i2c_rd;
        next_i2c_ack = i2c_ack;
        next_sda_oe  = host_out.sda_oe;
        i2c_wr       = 1'b0;
        if (!i2c_mode)
        begin
            next_i2c_st = I_IDLE;
            next_sda_oe = 1'b0;
        end
        else if (i2c_start)
        begin
            next_i2c_st  = I_RX;
            next_i2c_cnt = 4'h0;
            next_i2c_idx = 2'h0;
            next_sda_oe  = 1'b0;
        end
        else if (i2c_stop)
        begin
            next_i2c_st = I_IDLE;
            next_sda_oe = 1'b0;
        end
        else
        begin
            case (i2c_st)
                I_RX:
                    if (sck_rise)
                    begin
                        next_i2c_sh  = {i2c_sh[6:0], host_s.si_sda};
                        next_i2c_cnt = i2c_cnt + 4'h1;
                    end
                    else if (sck_fall && i2c_cnt == BYTE_BITS)
                    begin
                        next_i2c_cnt = 4'h0;
                        next_i2c_st  = I_ACK;
                        next_sda_oe  = 1'b1;
                        if (i2c_idx == 2'h0)
                        begin
                            next_i2c_rd = i2c_sh[0];
                            if (i2c_sh[7:1] != {I2C_ADDR_HI, host_s.host_select_or_addr_bit})
                            begin
                                next_i2c_st = I_IDLE;
                                next_sda_oe = 1'b0;
                            end
                        end
                        else if (i2c_idx == 2'h1)
                            next_i2c_ptr = i2c_sh[6:0];
                        else
                            i2c_wr = 1'b1;
                    end
                I_ACK:
                    if (sck_fall)
                    begin
                        next_i2c_cnt = 4'h0;
                        if (i2c_rd)
                        begin
                            next_i2c_st = I_TX;
                            next_i2c_sh = rd_byte;
                            next_sda_oe = ~rd_byte[7];
                        end
                        else
                        begin
                            next_i2c_st  = I_RX;
                            next_sda_oe  = 1'b0;
                            next_i2c_idx = (i2c_idx == 2'h2) ? 2'h2 : i2c_idx + 2'h1;
                        end
                    end
                I_TX:
                    if (sck_rise)
                        next_i2c_cnt = i2c_cnt + 4'h1;
                    else if (sck_fall && i2c_cnt == BYTE_BITS)
                    begin
                        next_i2c_st = I_TXACK;
                        next_sda_oe = 1'b0;
                    end
                    else if (sck_fall)
                    begin
                        next_i2c_sh = {i2c_sh[6:0], 1'b0};
                        next_sda_oe = ~i2c_sh[6];
                    end
                I_TXACK:
                    if (sck_rise)
                        next_i2c_ack = ~host_s.si_sda;
                    else if (sck_fall && i2c_ack)
                    begin
                        next_i2c_st  = I_TX;
                        next_i2c_cnt = 4'h0;
                        next_i2c_sh  = rd_byte;
                        next_sda_oe  = ~rd_byte[7];
                    end
                    else if (sck_fall)
                        next_i2c_st = I_IDLE;
                default:
                    next_i2c_st = I_IDLE;
            endcase
        end
    end

    assign next_host_out = '{so: next_so, so_oe: next_so_oe, scl_o: 1'b0, scl_oe: 1'b0,
                             sda_o: 1'b0, sda_oe: next_sda_oe};

    // Host port registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            spi_cnt  <= 4'h0;
            spi_sh   <= 8'h00;
            spi_out  <= 8'h00;
            spi_addr <= 7'h00;
            spi_rd   <= 1'b0;
            spi_byte <= 1'b0;
            i2c_st   <= I_IDLE;
            i2c_cnt  <= 4'h0;
            i2c_sh   <= 8'h00;
            i2c_idx  <= 2'h0;
            i2c_ptr  <= 7'h00;
            i2c_rd   <= 1'b0;
            i2c_ack  <= 1'b0;
            host_out <= '0;
        end
        else if (ce)
        begin
            spi_cnt  <= next_spi_cnt;
            spi_sh   <= next_spi_sh;
            spi_out  <= next_spi_out;
            spi_addr <= next_spi_addr;
            spi_rd   <= next_spi_rd;
            spi_byte <= next_spi_byte;
            i2c_st   <= next_i2c_st;
            i2c_cnt  <= next_i2c_cnt;
            i2c_sh   <= next_i2c_sh;
            i2c_idx  <= next_i2c_idx;
            i2c_ptr  <= next_i2c_ptr;
            i2c_rd   <= next_i2c_rd;
            i2c_ack  <= next_i2c_ack;
            host_out <= next_host_out;
        end
    end

    // Checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_lock_change;
        ce && (loop_status.locked != loop_a_locked);
    endsequence
    sequence s_deselect;
        ce && !i2c_mode && host_s.host_select_or_addr_bit;
    endsequence
    sequence s_addr_match;
        ce && i2c_st == I_RX && sck_fall && i2c_cnt == BYTE_BITS && i2c_idx == 2'h0
            && i2c_sh[7:1] == {I2C_ADDR_HI, host_s.host_select_or_addr_bit};
    endsequence

    property p_strap_capture;
        $fell(rst) |-> loop_a_mode_select[1:0]
            == $past({strap_s.loop_a_mode_pin_hi, strap_s.loop_a_mode_pin_lo});
    endproperty
    a_strap_capture: assert property (p_strap_capture) else $error("strap not captured");
    property p_mode_follow;
        ce && !loop_a_mode_select[MODE_SW_BIT] ##1 ce && !loop_a_mode_select[MODE_SW_BIT]
            |=> loop_a_mode == $past({strap_s.loop_a_mode_pin_hi, strap_s.loop_a_mode_pin_lo});
    endproperty
    a_mode_follow: assert property (p_mode_follow) else $error("mode not from pins");
    property p_mode_reg;
        ce && loop_a_mode_select[MODE_SW_BIT] |=> loop_a_mode == $past(loop_a_mode_select[1:0]);
    endproperty
    a_mode_reg: assert property (p_mode_reg) else $error("mode not from register");
    property p_role;
        ce && !role_ctl[ROLE_SW_BIT] |=> slave_role == $past(strap_s.role_slave_pin);
    endproperty
    a_role: assert property (p_role) else $error("role mismatch");
    property p_diff;
        ce |=> diff_out_a_drive == $past(strap_s.diff_out_a_enable)
            && diff_out_b_drive == $past(strap_s.diff_out_b_enable);
    endproperty
    a_diff: assert property (p_diff) else $error("driver enable mismatch");
    property p_status;
        ce |=> loop_a_locked == $past(loop_status.locked)
            && loop_a_in_hold == $past(loop_status.in_hold);
    endproperty
    a_status: assert property (p_status) else $error("status pin mismatch");
    property p_event_sticky;
        s_lock_change |=> irq_service_regs[EV_LOCK_BIT] ##1 (!ce || int_oe || !irq_enable[0]);
    endproperty
    a_event_sticky: assert property (p_event_sticky) else $error("lock event lost");
    property p_int_release;
        ce && !(|(irq_service_regs & irq_enable)) |=> !int_oe;
    endproperty
    a_int_release: assert property (p_int_release) else $error("interrupt not released");
    property p_so_drive;
        ce |=> host_out.so_oe == !$past(i2c_mode);
    endproperty
    a_so_drive: assert property (p_so_drive) else $error("serial output enable wrong");
    property p_spi_no_od;
        ce && !i2c_mode |=> !host_out.sda_oe && !host_out.scl_oe;
    endproperty
    a_spi_no_od: assert property (p_spi_no_od) else $error("open drain driven in SPI mode");
    property p_deselect;
        s_deselect |=> spi_cnt == 4'h0 && !spi_byte;
    endproperty
    a_deselect: assert property (p_deselect) else $error("SPI not idle when deselected");
    property p_addr_ack;
        s_addr_match |=> i2c_st == I_ACK && host_out.sda_oe;
    endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address not acknowledged");
    property p_reset_default;
        $fell(rst) |-> !int_oe && !loop_a_locked && i2c_st == I_IDLE && spi_cnt == 4'h0;
    endproperty
    a_reset_default: assert property (p_reset_default) else $error("reset state wrong");

endmodule
`default_nettype wire

// file: rtl/sync_ctl_pkg.sv
// Purpose: Shared constants, pin groups and states for the synchronizer control block
// Assumes: Register addresses are 7 bits, register data 8 bits
// Notes:
// Operation
// - Mode pins sampled during reset set default
// - Mode follows pins or mode register 0x1F
// - Role pin high slave, low master
// - Differential driver enabled while enable high
// - Lock output follows loop lock state
// - Holdover output follows loop holdover state
// - Interface select high I2C, low SPI
// - Clock pin: SPI clock or I2C clock
// - Data pin: SPI input or I2C data
// - Serial output drives SPI reads, idle in I2C
// - Select pin: SPI chip select or address bit
// - Interrupt pulled low on status change enabled in interrupt enable register 0x23
// - Reset of 300 ns restores defaults
package sync_ctl_pkg;

    // Timing
    localparam int CLK_PERIOD_NS = 25;
    localparam int RESET_MIN_NS  = 300;
    localparam int RESET_MIN_CYC = (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Register addresses
    localparam logic [6:0] REG_MODE   = 7'h1f;
    localparam logic [6:0] REG_ROLE   = 7'h20;
    localparam logic [6:0] REG_STATUS = 7'h21;
    localparam logic [6:0] REG_IRQ_SVC = 7'h22;
    localparam logic [6:0] REG_IEN    = 7'h23;

    // Field positions
    localparam int MODE_SW_BIT    = 2;
    localparam int ROLE_SW_BIT    = 0;
    localparam int ROLE_SLAVE_BIT = 1;
    localparam int ST_LOCK_BIT    = 0;
    localparam int ST_HOLD_BIT    = 1;
    localparam int ST_SLAVE_BIT   = 2;
    localparam int ST_I2C_BIT     = 3;
    localparam int EV_LOCK_BIT    = 0;
    localparam int EV_HOLD_BIT    = 1;
    localparam int SPI_READ_BIT   = 7;

    // Writable bit masks
    localparam logic [7:0] MODE_WR_MASK = 8'h07;
    localparam logic [7:0] ROLE_WR_MASK = 8'h03;
    localparam logic [7:0] EV_MASK      = 8'h03;

    // Values after reset
    localparam logic [5:0] MODE_RST_HI = 6'h00;
    localparam logic [7:0] ROLE_RST    = 8'h00;
    localparam logic [7:0] IRQ_SVC_RST = 8'h00;
    localparam logic [7:0] IEN_RST     = 8'h00;

    // Serial framing
    localparam logic [3:0] BYTE_BITS   = 4'h8;
    localparam logic [3:0] SPI_LAST    = 4'h7;
    localparam logic [5:0] I2C_ADDR_HI = 6'h2a;

    typedef struct packed {
        logic loop_a_mode_pin_hi;
        logic loop_a_mode_pin_lo;
        logic role_slave_pin;
        logic diff_out_a_enable;
        logic diff_out_b_enable;
        logic i2c_select_pin;
    } strap_pins_t;

    typedef struct packed {
        logic sck_scl;
        logic si_sda;
        logic host_select_or_addr_bit;
    } host_pins_in_t;

    typedef struct packed {
        logic so;
        logic so_oe;
        logic scl_o;
        logic scl_oe;
        logic sda_o;
        logic sda_oe;
    } host_pins_out_t;

    typedef struct packed {
        logic locked;
        logic in_hold;
    } loop_status_t;

    typedef enum logic [2:0] {
        I_IDLE,
        I_RX,
        I_ACK,
        I_TX,
        I_TXACK
    } i2c_state_t;

endpackage

// file: rtl/sync_bank.sv
// Purpose: Two-stage synchroniser for a bank of pin inputs
// Assumes: Inputs are asynchronous to ref_clk
// Notes: Stages carry no reset; they settle within two edges of reset
`timescale 1ns/1ps
`default_nettype none
module sync_bank #(
    parameter int WIDTH = 1
) (
    input  wire logic             ref_clk,
    input  wire logic             ce,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);

    logic [WIDTH-1:0] stage1;

    // One synchroniser per bit
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            always_ff @(posedge ref_clk)
            begin
                if (ce)
                begin
                    stage1[i] <= d[i];
                    q[i]      <= stage1[i];
                end
            end
        end
    endgenerate

endmodule
`default_nettype wire

// file: tb/host_spi_model.sv
// Purpose: Host processor model speaking SPI mode 0 or I2C to the block
// Assumes: 200 ns serial clock, each half 4 ref_clk cycles
// Notes: SPI clock stands low between commands, I2C clock high
`timescale 1ns/1ps
`default_nettype none
module host_spi_model (
    output logic      sck,
    output logic      si,
    output logic      cs_n,
    input  wire logic so,
    input  wire logic sda
);
    // Idle bus
    initial
    begin
        sck = 1'b0;
        si = 1'b0;
        cs_n = 1'b1;
    end
    // Two bytes MSB first, read byte taken on rising edges
    task automatic xfer(input logic [15:0] tx, output logic [7:0] rx);
        rx = 8'h00;
        cs_n = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            si = tx[i];
            #100 sck = 1'b1;
            if (i < 8)
                rx = {rx[6:0], so};
            #100 sck = 1'b0;
        end
        #100 cs_n = 1'b1;
        si = ~si; // Released line shows no stale level
        #300;
    endtask
    // I2C write of three bytes; each ninth clock samples the ack
    task automatic i2c_xfer(input logic [23:0] tx, output logic [2:0] ack);
        ack = 3'b000;
        sck = 1'b1;
        si = 1'b1;
        #200 si = 1'b0; // Start: data falls while clock high
        #100 sck = 1'b0;
        for (int b = 2; b >= 0; b--)
        begin
            for (int i = 8; i >= 0; i--)
            begin
                si = (i == 0) ? 1'b1 : tx[8 * b + i - 1];
                #100 sck = 1'b1;
                if (i == 0)
                    ack[b] = ~sda;
                #100 sck = 1'b0;
            end
        end
        si = 1'b0;
        #100 sck = 1'b1;
        #100 si = 1'b1; // Stop: data rises while clock high
        #300;
    endtask
endmodule
`default_nettype wire

// file: tb/tb_sync_control_status_host_pins.sv
// Purpose: Register and pin tests of the control block over SPI and I2C
// Assumes: SPI host port, then I2C; ce held high
// Notes: Reset held for the minimum reset time
`timescale 1ns/1ps
`default_nettype none
module tb_sync_control_status_host_pins;
    import sync_ctl_pkg::*;
    logic           ref_clk = 1'b0;
    logic           rst = 1'b1;
    strap_pins_t    straps = 6'b100000;
    loop_status_t   lstat = 2'b00;
    host_pins_out_t hout;
    logic [1:0]     mode;
    logic           slave, drv_a, drv_b, lck, hld, int_n, int_oe, sck, si, cs_n;
    logic [7:0]     rx;
    logic [2:0]     ack;
    int             error_cnt = 0;
    int             n_compared = 0;
    // Clock and hang guard
    initial
    forever #12.5 ref_clk = ~ref_clk;
    initial
    begin
        #1000000 error_cnt++;
        end_sim();
    end
    host_spi_model host_spi_model_i (.sck(sck), .si(si), .cs_n(cs_n),
        .so(hout.so_oe ? hout.so : ~hout.so), .sda(si & ~hout.sda_oe));
    sync_control_status_host_pins sync_control_status_host_pins_i (
        .ref_clk(ref_clk), .rst(rst), .ce(1'b1), .strap_pins(straps),
        .loop_status(lstat), .host_in({sck, si & ~hout.sda_oe, cs_n}), .loop_a_mode(mode),
        .slave_role(slave), .diff_out_a_drive(drv_a), .diff_out_b_drive(drv_b),
        .loop_a_locked(lck), .loop_a_in_hold(hld), .host_out(hout),
        .int_n_o(int_n), .int_oe(int_oe));
    // Compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic end_sim;
        $display("compared=%0d errors=%0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk);
    endtask
    // Main sequence
    initial
    begin
        wait_cyc(RESET_MIN_CYC);
        rst = 1'b0;
        wait_cyc(4);
        chk(mode, 2'b10);
        chk(hout.so_oe, 1'b1);
        chk(drv_a, 1'b0);
        straps = 6'b011100;
        wait_cyc(5);
        chk(mode, 2'b01);
        chk({slave, drv_a, drv_b}, 3'b110);
        host_spi_model_i.xfer({1'b0, REG_MODE, 8'h06}, rx);
        chk(mode, 2'b10);
        host_spi_model_i.xfer({1'b1, REG_MODE, 8'h00}, rx);
        chk(rx, 8'h06);
        host_spi_model_i.xfer({1'b0, REG_IEN, 8'h01}, rx);
        lstat = 2'b10;
        wait_cyc(3);
        chk({lck, int_oe, int_n}, 3'b110);
        lstat = 2'b11;
        wait_cyc(3);
        chk(hld, 1'b1);
        host_spi_model_i.xfer({1'b1, REG_STATUS, 8'h00}, rx);
        chk(rx, 8'h07);
        host_spi_model_i.xfer({1'b0, REG_IRQ_SVC, 8'h01}, rx);
        chk(int_oe, 1'b0);
        host_spi_model_i.xfer({1'b0, REG_ROLE, 8'h01}, rx);
        chk(slave, 1'b0);
        host_spi_model_i.xfer({1'b1, 7'h40, 8'h00}, rx);
        chk(rx, 8'h00);
        straps = 6'b010011;
        wait_cyc(5);
        chk({slave, drv_a, drv_b}, 3'b001);
        chk({hout.so_oe, hout.sda_oe}, 2'b00);
        host_spi_model_i.i2c_xfer({I2C_ADDR_HI, 2'b10, 1'b0, REG_MODE, 8'h07}, ack);
        chk(ack, 3'b111);
        chk(mode, 2'b11);
        end_sim();
    end
endmodule
`default_nettype wire
